// ===== ips_pkg.sv
package ips_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned TRIAL_S = 90;
  localparam int unsigned RETRY_S = 300;
  localparam int unsigned RESET_WAIT_S = 30;
  localparam int unsigned STAB_MS = 1000;
  localparam int unsigned DEBOUNCE_US = 1000;
  localparam longint unsigned TRIAL_CYC = longint'(TRIAL_S) * CLK_HZ;
  localparam longint unsigned RETRY_CYC = longint'(RETRY_S) * CLK_HZ;
  localparam longint unsigned RESET_WAIT_CYC = longint'(RESET_WAIT_S) * CLK_HZ;
  localparam longint unsigned STAB_CYC = longint'(STAB_MS) * (CLK_HZ / 1000);
  localparam longint unsigned DEBOUNCE_CYC = longint'(DEBOUNCE_US) * (CLK_HZ / 1_000_000);
  localparam int CNT_W = 40;
  localparam int DB_W = 20;

  typedef enum logic [2:0] {
    IPS_IDLE = 3'b000,
    IPS_TRIAL = 3'b001,
    IPS_STAB = 3'b011,
    IPS_RUN = 3'b010,
    IPS_RETRY = 3'b110,
    IPS_SHUT = 3'b111
  } ips_state_e;

  typedef struct packed {
    logic heatReq;
    logic flameLow;
    logic flameHigh;
  } ips_in_s;

  typedef struct packed {
    logic sparkEn;
    logic pilotValve;
    logic mainValve;
  } ips_out_s;
endpackage

// ===== ips_sequencer.sv
// Overview of operation
// - A new heat request turns on spark and pilot valve together, starting a trial.
// - In a trial, reaching the low flame level stops the spark while the pilot stays open.
// - The main valve opens only at the high flame level, never on the low level alone.
// - Spark comes back if flame drops below low level, but the trial never outlasts its time.
// - Without proved flame the spark ends when the trial time (90 s default) runs out.
// - After the main valve opens a stabilization interval passes, then run mode supervises flame.
// - Losing flame in run mode closes both pilot and main valves.
// - A trial that ends unproved closes spark and pilot, leaving all gas closed.
// - After a failed trial all outputs stay off for five minutes, then a new trial starts.
// - Trial and delay repeat without limit until flame is proved or the request ends.
// - Removing and reasserting the request, or a power reset, cuts the retry delay short.
// - After a shutoff, idle returns once the request has stayed off at least 30 seconds.
// - A request that goes inactive closes main valve, pilot valve and spark in any phase.
`timescale 1ns/1ps
module ips_sequencer #(
  parameter longint unsigned TRIAL_CYCLES = ips_pkg::TRIAL_CYC,
  parameter longint unsigned RETRY_CYCLES = ips_pkg::RETRY_CYC,
  parameter longint unsigned RESET_WAIT_CYCLES = ips_pkg::RESET_WAIT_CYC,
  parameter longint unsigned STAB_CYCLES = ips_pkg::STAB_CYC,
  parameter longint unsigned DEBOUNCE_CYCLES = ips_pkg::DEBOUNCE_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire ips_pkg::ips_in_s pinIn,
  output ips_pkg::ips_out_s valveOut,
  output ips_pkg::ips_state_e phase
);
  import ips_pkg::*;

  // Each limit lies one short of its interval; the state change takes the last cycle
  localparam logic [CNT_W-1:0] TRIAL_LIM = CNT_W'(TRIAL_CYCLES - 1);
  localparam logic [CNT_W-1:0] RETRY_LIM = CNT_W'(RETRY_CYCLES - 1);
  localparam logic [CNT_W-1:0] RWAIT_LIM = CNT_W'(RESET_WAIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] STAB_LIM = CNT_W'(STAB_CYCLES - 1);
  localparam logic [DB_W-1:0] DB_LIM = DB_W'(DEBOUNCE_CYCLES - 1);

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] clean;
    logic [2:0][DB_W-1:0] dbCnt;
    logic heatPrev;
    ips_state_e st;
    logic [CNT_W-1:0] trialCnt;
    logic [CNT_W-1:0] phaseCnt;
    logic [CNT_W-1:0] offCnt;
    ips_out_s out;
  } ips_reg_s;

  ips_reg_s q_r, q_nxt;
  logic heat, fLow, fHigh, heatRise;

  assign heat = q_r.clean[2];
  assign fLow = q_r.clean[1];
  assign fHigh = q_r.clean[0];
  assign heatRise = heat && !q_r.heatPrev;
  assign valveOut = q_r.out;
  assign phase = q_r.st;

  always_comb begin
    q_nxt = q_r;
    // Two-stage sync then hold-time debounce per input
    q_nxt.sync1 = {pinIn.heatReq, pinIn.flameLow, pinIn.flameHigh};
    q_nxt.sync2 = q_r.sync1;
    for (int i = 0; i < 3; i++) begin
      if (q_r.sync2[i] == q_r.clean[i]) begin
        q_nxt.dbCnt[i] = '0;
      end else if (q_r.dbCnt[i] == DB_LIM) begin
        q_nxt.clean[i] = q_r.sync2[i];
        q_nxt.dbCnt[i] = '0;
      end else begin
        q_nxt.dbCnt[i] = q_r.dbCnt[i] + 1'b1;
      end
    end
    q_nxt.heatPrev = heat;
    q_nxt.offCnt = heat ? '0 : ((q_r.offCnt == RWAIT_LIM) ? q_r.offCnt : q_r.offCnt + 1'b1);
    q_nxt.phaseCnt = q_r.phaseCnt + 1'b1;
    q_nxt.trialCnt = q_r.trialCnt + 1'b1;
    unique case (q_r.st)
      IPS_IDLE: begin
        q_nxt.out = '0;
        if (heatRise) begin
          q_nxt.st = IPS_TRIAL;
          q_nxt.trialCnt = '0;
          q_nxt.out = '{sparkEn: 1'b1, pilotValve: 1'b1, mainValve: 1'b0};
        end
      end
      IPS_TRIAL: begin
        q_nxt.out.pilotValve = 1'b1;
        q_nxt.out.sparkEn = !fLow;
        if (!heat) begin
          q_nxt.st = IPS_IDLE;
          q_nxt.out = '0;
        end else if (fHigh && fLow) begin
          q_nxt.st = IPS_STAB;
          q_nxt.phaseCnt = '0;
          q_nxt.out = '{sparkEn: 1'b0, pilotValve: 1'b1, mainValve: 1'b1};
        end else if (q_r.trialCnt >= TRIAL_LIM) begin
          q_nxt.st = IPS_RETRY;
          q_nxt.phaseCnt = '0;
          q_nxt.out = '0;
        end
      end
      IPS_STAB: begin
        // Flame level is not judged while the main flame settles
        if (!heat) begin
          q_nxt.st = IPS_IDLE;
          q_nxt.out = '0;
        end else if (q_r.phaseCnt >= STAB_LIM) begin
          q_nxt.st = IPS_RUN;
        end
      end
      IPS_RUN: begin
        if (!heat) begin
          q_nxt.st = IPS_IDLE;
          q_nxt.out = '0;
        end else if (!fLow) begin
          q_nxt.st = IPS_SHUT;
          q_nxt.out = '0;
        end
      end
      IPS_RETRY: begin
        q_nxt.out = '0;
        if (heatRise) begin
          q_nxt.st = IPS_TRIAL;
          q_nxt.trialCnt = '0;
          q_nxt.out = '{sparkEn: 1'b1, pilotValve: 1'b1, mainValve: 1'b0};
        end else if (!heat && q_r.offCnt == RWAIT_LIM) begin
          q_nxt.st = IPS_IDLE;
        end else if (heat && q_r.phaseCnt >= RETRY_LIM) begin
          q_nxt.st = IPS_TRIAL;
          q_nxt.trialCnt = '0;
          q_nxt.out = '{sparkEn: 1'b1, pilotValve: 1'b1, mainValve: 1'b0};
        end
      end
      IPS_SHUT: begin
        q_nxt.out = '0;
        if (heatRise) begin
          q_nxt.st = IPS_TRIAL;
          q_nxt.trialCnt = '0;
          q_nxt.out = '{sparkEn: 1'b1, pilotValve: 1'b1, mainValve: 1'b0};
        end else if (!heat && q_r.offCnt == RWAIT_LIM) begin
          q_nxt.st = IPS_IDLE;
        end
      end
      default: begin
        q_nxt.st = IPS_IDLE;
        q_nxt.out = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Properties on the registered outputs and the sequencing state
  a_spark_pilot_start: assert property (@(posedge clk) disable iff (sys_rst)
    (q_r.st == IPS_IDLE && heatRise) |=> (valveOut.sparkEn && valveOut.pilotValve))
    else $error("spark and pilot did not start together");
  a_spark_off_low: assert property (@(posedge clk) disable iff (sys_rst)
    (q_r.st == IPS_TRIAL && heat && fLow && q_r.trialCnt < TRIAL_LIM)
    |=> (!valveOut.sparkEn && valveOut.pilotValve))
    else $error("spark not stopped at low flame");
  a_spark_back_on: assert property (@(posedge clk) disable iff (sys_rst)
    (q_r.st == IPS_TRIAL && heat && !fLow && q_r.trialCnt < TRIAL_LIM)
    |=> (valveOut.sparkEn && valveOut.pilotValve))
    else $error("spark not restored after flame dropped");
  a_trial_no_main: assert property (@(posedge clk) disable iff (sys_rst)
    (q_r.st == IPS_TRIAL) |-> !valveOut.mainValve)
    else $error("main valve open during trial");
  a_low_not_main: assert property (@(posedge clk) disable iff (sys_rst)
    (q_r.st == IPS_TRIAL && heat && fLow && !fHigh) |=> !valveOut.mainValve)
    else $error("main valve opened on low flame alone");
  a_high_opens_main: assert property (@(posedge clk) disable iff (sys_rst)
    (q_r.st == IPS_TRIAL && heat && fLow && fHigh)
    |=> (q_r.st == IPS_STAB && valveOut.mainValve && !valveOut.sparkEn))
    else $error("high flame did not open main valve");
  a_main_needs_high: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(valveOut.mainValve) |-> $past(fHigh))
    else $error("main valve opened without high flame");
  a_trial_bound: assert property (@(posedge clk) disable iff (sys_rst)
    (q_r.st == IPS_TRIAL) |-> (q_r.trialCnt <= TRIAL_LIM))
    else $error("trial overran its time");
  a_trial_timeout: assert property (@(posedge clk) disable iff (sys_rst)
    (q_r.st == IPS_TRIAL && heat && !fHigh && q_r.trialCnt == TRIAL_LIM)
    |=> (valveOut == '0 && q_r.st == IPS_RETRY))
    else $error("failed trial did not close gas");
  a_flame_loss: assert property (@(posedge clk) disable iff (sys_rst)
    (q_r.st == IPS_RUN && heat && !fLow) |=> (!valveOut.pilotValve && !valveOut.mainValve))
    else $error("flame loss did not close valves");
  a_retry_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    (q_r.st == IPS_RETRY) |-> (valveOut == '0))
    else $error("outputs active during retry delay");
  a_heat_off_close: assert property (@(posedge clk) disable iff (sys_rst)
    (!heat && q_r.st != IPS_IDLE) |=> (valveOut == '0))
    else $error("outputs on after request ended");
  a_stab_to_run: assert property (@(posedge clk) disable iff (sys_rst)
    (q_r.st == IPS_STAB && heat && q_r.phaseCnt == STAB_LIM) |=> (q_r.st == IPS_RUN))
    else $error("stabilization did not lead to run");
  a_retry_restart: assert property (@(posedge clk) disable iff (sys_rst)
    (q_r.st == IPS_RETRY && heat && q_r.phaseCnt == RETRY_LIM)
    |=> (q_r.st == IPS_TRIAL && valveOut.sparkEn && valveOut.pilotValve))
    else $error("retry delay did not start a new trial");
  a_retry_holds: assert property (@(posedge clk) disable iff (sys_rst)
    (q_r.st == IPS_RETRY && heat && !heatRise && q_r.phaseCnt < RETRY_LIM)
    |=> (q_r.st == IPS_RETRY))
    else $error("retry delay ended early");
  a_cycle_restart: assert property (@(posedge clk) disable iff (sys_rst)
    (q_r.st inside {IPS_RETRY, IPS_SHUT} && heatRise) |=> (q_r.st == IPS_TRIAL))
    else $error("reasserted request did not restart trial");
  a_reset_wait_idle: assert property (@(posedge clk) disable iff (sys_rst)
    (q_r.st inside {IPS_RETRY, IPS_SHUT} && !heat && q_r.offCnt == RWAIT_LIM)
    |=> (q_r.st == IPS_IDLE))
    else $error("long request off did not return to idle");
  a_debounce_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (q_r.dbCnt[2] != DB_LIM) |=> (q_r.clean[2] == $past(q_r.clean[2])))
    else $error("request changed before debounce ran out");
endmodule // ips_sequencer

// ===== ips_flame_model.sv
`timescale 1ns/1ps
module ips_flame_model (
  input wire logic clk,
  input wire logic pilotValve,
  input wire logic [1:0] gasLevel,
  output logic flameLow,
  output logic flameHigh
);
  // Flame needs pilot gas and dies as soon as the pilot valve closes
  always @(negedge clk) begin
    flameLow <= pilotValve && (gasLevel != 2'h0);
    flameHigh <= pilotValve && (gasLevel == 2'h2);
  end
endmodule // ips_flame_model

// ===== test_ips_sequencer.sv
`timescale 1ns/1ps
module test_ips_sequencer;
  import ips_pkg::*;
  typedef struct {logic [5:0] v; int gap;} ips_exp_s;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic heatReq = 1'b0;
  logic [1:0] gasLevel = 2'h0;
  logic [15:0] rnd = 16'h2d72;
  logic flameLow;
  logic flameHigh;
  ips_in_s pinIn;
  ips_out_s valveOut;
  ips_state_e phase;
  ips_exp_s expQ[$];
  ips_exp_s e;
  logic [5:0] lastSeen = 6'h00;
  int cyc = 0;
  int lastCyc = 0;
  int fails = 0;
  int check_count = 0;
  always #2 clk = ~clk;
  assign pinIn = {heatReq, flameLow, flameHigh};
  ips_sequencer #(.TRIAL_CYCLES(200), .RETRY_CYCLES(300), .RESET_WAIT_CYCLES(100),
    .STAB_CYCLES(20), .DEBOUNCE_CYCLES(4)) i_ips_sequencer (.clk(clk), .sys_rst(sys_rst),
    .pinIn(pinIn), .valveOut(valveOut), .phase(phase));
  ips_flame_model i_ips_flame_model (.clk(clk), .pilotValve(valveOut.pilotValve),
    .gasLevel(gasLevel), .flameLow(flameLow), .flameHigh(flameHigh));
  // Every output change takes the oldest note; gap is cycles since the previous change
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!sys_rst && {phase, valveOut} !== lastSeen) begin
      lastSeen <= {phase, valveOut};
      lastCyc <= cyc;
      check_count++;
      e = expQ.size() != 0 ? expQ.pop_front() : ips_exp_s'{6'h3f, -1};
      if (e.v !== {phase, valveOut} || (e.gap != 0 && cyc - lastCyc != e.gap)) begin
        fails++;
        $display("Error outputs expected %h gap %0d seen %h gap %0d",
          e.v, e.gap, {phase, valveOut}, cyc - lastCyc);
      end
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic expect_out(input logic [5:0] v, input int gap);
    expQ.push_back('{v, gap});
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rwait();
    rnd = lfsr(rnd);
    idle(15 + int'(rnd[2:0]));
  endtask
  task automatic drain(input int limit);
    for (int i = 0; i < limit && expQ.size() != 0; i++) @(negedge clk);
    if (expQ.size() != 0) begin
      fails++;
      $display("Error queue expected 0 seen %0d", expQ.size());
      report_and_stop();
    end
  endtask
  task automatic report_and_stop();
    $display("Counts checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    // A request pulse shorter than the debounce must move nothing
    heatReq = 1'b1;
    idle(2);
    heatReq = 1'b0;
    rwait();
    $display("Test glitch done");
    heatReq = 1'b1;
    expect_out({IPS_TRIAL, 3'h6}, 0);
    expect_out({IPS_RETRY, 3'h0}, 200);
    expect_out({IPS_TRIAL, 3'h6}, 300);
    expect_out({IPS_RETRY, 3'h0}, 200);
    drain(1000);
    heatReq = 1'b0;
    rwait();
    heatReq = 1'b1;
    expect_out({IPS_TRIAL, 3'h6}, 0);
    drain(40);
    expect_out({IPS_RETRY, 3'h0}, 200);
    drain(300);
    // A reset in the retry delay with the request held starts a trial as soon as the request has passed sync and debounce again
    sys_rst = 1'b1;
    idle(2);
    sys_rst = 1'b0;
    expect_out({IPS_IDLE, 3'h0}, 0);
    expect_out({IPS_TRIAL, 3'h6}, 0);
    drain(40);
    heatReq = 1'b0;
    expect_out({IPS_IDLE, 3'h0}, 0);
    drain(40);
    rwait();
    $display("Test retry done");
    gasLevel = 2'h1;
    heatReq = 1'b1;
    expect_out({IPS_TRIAL, 3'h6}, 0);
    expect_out({IPS_TRIAL, 3'h2}, 0);
    drain(40);
    gasLevel = 2'h0;
    expect_out({IPS_TRIAL, 3'h6}, 0);
    drain(40);
    gasLevel = 2'h1;
    expect_out({IPS_TRIAL, 3'h2}, 0);
    drain(40);
    rwait();
    gasLevel = 2'h2;
    expect_out({IPS_STAB, 3'h3}, 0);
    expect_out({IPS_RUN, 3'h3}, 20);
    drain(60);
    gasLevel = 2'h0;
    expect_out({IPS_SHUT, 3'h0}, 0);
    drain(40);
    heatReq = 1'b0; // held low past the reset wait
    expect_out({IPS_IDLE, 3'h0}, 0);
    drain(150);
    $display("Test flame done");
    report_and_stop();
  end
endmodule // test_ips_sequencer
